//--- test/pwm_with_period_timer_tb_top.sv
// self-checking bench of the pwm block: registers, period, duty, flag
`timescale 1ns/1ps
`include "pwt_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pwm_with_period_timer_tb_top;
    import pwt_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pin, err;
    pwt_addr_t paddr = 12'h000;
    pwt_word_t pwdata = 32'h0, prdata;
    pwt_byte_t rd;
    int high_len, period_len, rises, fail_count = 0, checked = 0;
    // 100 mhz clock
    always #5 sys_clk = ~sys_clk;
    pwt_top dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pulse_output_pin(pin));
    pwt_load_model load (.sys_clk(sys_clk), .pin(pin), .high_len(high_len), .period_len(period_len), .rises(rises));
    // verdict and end of run
    task automatic results;
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // one apb transfer, then release and one idle cycle
    task automatic apb(input logic wr, input pwt_byte_t idx, input pwt_byte_t wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 40) begin
            fail_count++;
            results();
        end
    endtask : apb
    // read one register and compare
    task automatic rd_chk(input pwt_byte_t idx, input pwt_byte_t exp);
        apb(1'b0, idx, 8'h00);
        `CHK("read data", exp, rd);
        `CHK("read error", 1'b0, err);
    endtask : rd_chk
    // pin must keep one level for 40 cycles
    task automatic hold_chk(input logic lvl);
        int bad;
        bad = 0;
        repeat (40) begin
            @(posedge sys_clk);
            bad += int'(pin !== lvl);
        end
        `CHK("pin level misses", 0, bad);
    endtask : hold_chk
    // waits three rises, then compares period and high time
    task automatic per_chk(input int per, input int hi);
        int n;
        int k;
        n = rises + 3;
        for (k = 0; k < 3000 && rises < n; k++)
            @(posedge sys_clk);
        if (k >= 3000) begin
            fail_count++;
            results();
        end
        `CHK("period", per, period_len);
        `CHK("high time", hi, high_len);
    endtask : per_chk
    // reset values
    task automatic t_reset;
        pwt_byte_t idx[6] = '{`PWT_IDX_PT_COUNT, `PWT_IDX_PT_CTRL, `PWT_IDX_PLIMIT, `PWT_IDX_PFLAGS,
            `PWT_IDX_PENABLES, `PWT_IDX_INTR_CTL};
        pwt_byte_t val[6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++)
            rd_chk(idx[i], val[i]);
    endtask : t_reset
    // read-write registers with the timer stopped, unmapped place
    task automatic t_regs;
        apb(1'b1, `PWT_IDX_PT_COUNT, 8'h5a);
        repeat (20) @(posedge sys_clk);
        rd_chk(`PWT_IDX_PT_COUNT, 8'h5a);
        apb(1'b1, `PWT_IDX_PT_CTRL, 8'hf3);
        rd_chk(`PWT_IDX_PT_CTRL, 8'h73);
        apb(1'b1, `PWT_IDX_PENABLES, 8'h02);
        rd_chk(`PWT_IDX_PENABLES, 8'h02);
        apb(1'b1, `PWT_IDX_INTR_CTL, 8'hc0);
        rd_chk(`PWT_IDX_INTR_CTL, 8'hc0);
        apb(1'b1, 8'h10, 8'h55);
        `CHK("unmapped error", 1'b1, err);
        apb(1'b0, 8'h10, 8'h00);
        `CHK("unmapped read", 8'h00, rd);
    endtask : t_regs
    // duty six over limit three, at every prescale
    task automatic t_pwm;
        pwt_byte_t ctl[3] = '{8'h04, 8'h05, 8'h06};
        int ps[3] = '{1, 4, 16};
        apb(1'b1, `PWT_IDX_PT_COUNT, 8'h00);
        apb(1'b1, `PWT_IDX_PLIMIT, 8'h03);
        apb(1'b1, `PWT_IDX_DUTY_WR, 8'h01);
        apb(1'b1, `PWT_IDX_MOD_CTRL, 8'h2c);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `PWT_IDX_PT_CTRL, ctl[i]);
            per_chk(16 * ps[i], 6 * ps[i]);
        end
        rd_chk(`PWT_IDX_DUTY_BUF, 8'h01);
        apb(1'b1, `PWT_IDX_DUTY_BUF, 8'h77);
        rd_chk(`PWT_IDX_DUTY_BUF, 8'h01);
    endtask : t_pwm
    // flag after two matches, sticky, period unchanged by postscale
    task automatic t_flag;
        apb(1'b1, `PWT_IDX_PT_CTRL, 8'h00);
        apb(1'b1, `PWT_IDX_PT_COUNT, 8'h00);
        apb(1'b1, `PWT_IDX_PFLAGS, 8'h00);
        apb(1'b1, `PWT_IDX_PT_CTRL, 8'h0c);
        repeat (14) @(posedge sys_clk);
        rd_chk(`PWT_IDX_PFLAGS, 8'h00);
        repeat (16) @(posedge sys_clk);
        rd_chk(`PWT_IDX_PFLAGS, 8'h02);
        repeat (40) @(posedge sys_clk);
        rd_chk(`PWT_IDX_PFLAGS, 8'h02);
        apb(1'b1, `PWT_IDX_PT_CTRL, 8'h08);
        apb(1'b1, `PWT_IDX_PFLAGS, 8'h00);
        rd_chk(`PWT_IDX_PFLAGS, 8'h00);
        apb(1'b1, `PWT_IDX_PT_CTRL, 8'h0c);
        per_chk(16, 6);
    endtask : t_flag
    // zero duty, duty above period, module control cleared
    task automatic t_edge;
        apb(1'b1, `PWT_IDX_DUTY_WR, 8'h00);
        apb(1'b1, `PWT_IDX_MOD_CTRL, 8'h0c);
        repeat (40) @(posedge sys_clk);
        hold_chk(1'b0);
        apb(1'b1, `PWT_IDX_DUTY_WR, 8'hff);
        apb(1'b1, `PWT_IDX_MOD_CTRL, 8'h3c);
        repeat (40) @(posedge sys_clk);
        hold_chk(1'b1);
        apb(1'b1, `PWT_IDX_MOD_CTRL, 8'h00);
        `CHK("pin after clear", 1'b0, pin);
    endtask : t_edge
    // reset for ten cycles, then the scenarios
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_regs();
        t_pwm();
        t_flag();
        t_edge();
        results();
    end
endmodule : pwm_with_period_timer_tb_top
bind pwt_top pwt_props u_props (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pulse_output_pin(pulse_output_pin));

//--- test/pwt_load_model.sv
// load on the pulse pin: measures period and high time at each rising edge
`timescale 1ns/1ps
module pwt_load_model (
    input wire logic sys_clk, // clock
    input wire logic pin, // pulse pin, direction already set to output
    output int high_len, // high cycles of last period
    output int period_len, // cycles between last two rises
    output int rises // rising edges seen
);
    int hi_q = 0, per_q = 0;
    logic last_q = 1'b1;
    // counts cycles between rises and the high cycles among them
    always_ff @(posedge sys_clk) begin
        last_q <= pin;
        if (pin && !last_q) begin
            high_len <= hi_q;
            period_len <= per_q;
            rises <= rises + 1;
            hi_q <= 1;
            per_q <= 1;
        end else begin
            hi_q <= hi_q + int'(pin);
            per_q <= per_q + 1;
        end
    end
endmodule : pwt_load_model

//--- test/pwt_props.sv
// concurrent checks on the apb side and pulse pin of the pwm block
`timescale 1ns/1ps
`include "pwt_defs.svh"
module pwt_props (
    input wire logic sys_clk, // clock
    input wire logic srst, // reset
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // write
    input wire pwt_pkg::pwt_addr_t paddr, // address
    input wire pwt_pkg::pwt_word_t pwdata, // write data
    input wire logic pready, // ready
    input wire pwt_pkg::pwt_word_t prdata, // read data
    input wire logic pslverr, // error
    input wire logic pulse_output_pin // pulse pin
);
    import pwt_pkg::*;
    logic mode_q;
    logic mapped;
    // address decodes to one of the byte registers
    assign mapped = paddr[1:0] == 2'b00 && paddr[11:2] inside {`PWT_IDX_INTR_CTL, `PWT_IDX_PFLAGS, `PWT_IDX_PT_COUNT,
        `PWT_IDX_PT_CTRL, `PWT_IDX_DUTY_WR, `PWT_IDX_DUTY_BUF, `PWT_IDX_MOD_CTRL, `PWT_IDX_PENABLES, `PWT_IDX_PLIMIT};
    // pwm mode as last written to module control
    always_ff @(posedge sys_clk) begin
        if (srst)
            mode_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr[11:2] == `PWT_IDX_MOD_CTRL)
            mode_q <= pwdata[3:2] == `PWT_PWM_MODE;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    a_ready_one_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("pready missing after one wait cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    a_ready_needs_req: assert property (pready |-> psel && penable && $past(psel))
        else $error("pready without a request");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
        else $error("error flag does not match the map");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_ctrl_bit_top: assert property (pready && !pwrite && paddr[11:2] == `PWT_IDX_PT_CTRL |-> !prdata[7])
        else $error("timer control bit seven not zero");
    a_pin_off: assert property (!mode_q [*3] |-> !pulse_output_pin)
        else $error("pin high outside pwm mode");
endmodule : pwt_props

//--- verilog/pwt_defs.svh
// register map, field positions, reset values and timing counts of the pwm block
// How it works
// - pwm mode drives pin with 10-bit duty
// - module control write of zero forces low
// - period is (limit+1) times 4 times prescale
// - timer clears on increment after limit match
// - duty copied into buffer on that increment
// - pin set then, unless loaded duty is zero
// - postscaler never changes the pwm period
// - timer count readable, writable, resets to zero
// - period limit resets to all ones
// - timer control fields, bit seven reads zero
// - match flag is bit one of flags
// - match enable is bit one of enables
// - global and peripheral enables, reset zero
// - duty is low register plus control bits
// - pin cleared when extended count equals duty
// - duty above period never clears the pin
// - duty buffer read only in pwm mode
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

// register indices; byte address is four times the index
`define PWT_IDX_INTR_CTL 8'h0b
`define PWT_IDX_PFLAGS 8'h0c
`define PWT_IDX_PT_COUNT 8'h11
`define PWT_IDX_PT_CTRL 8'h12
`define PWT_IDX_DUTY_WR 8'h15
`define PWT_IDX_DUTY_BUF 8'h16
`define PWT_IDX_MOD_CTRL 8'h17
`define PWT_IDX_PENABLES 8'h8c
`define PWT_IDX_PLIMIT 8'h92

// reset values
`define PWT_RST_ZERO 8'h00
`define PWT_RST_PLIMIT 8'hff

// field positions
`define PWT_BIT_MATCH 1
`define PWT_BIT_RUN 2
`define PWT_BIT_GIE 7
`define PWT_BIT_PERIPHERAL_IRQ_ENABLE 6
`define PWT_PWM_MODE 2'b11

// clock periods per instruction cycle and last prescaler counts
`define PWT_QCLK_PER 4
`define PWT_PSC_LAST_1 6'h03
`define PWT_PSC_LAST_4 6'h0f
`define PWT_PSC_LAST_16 6'h3f

`endif

//--- verilog/pwt_pkg.sv
// types shared by the pwm block
package pwt_pkg;
    typedef logic [7:0] pwt_byte_t;
    typedef logic [31:0] pwt_word_t;
    typedef logic [11:0] pwt_addr_t;
    typedef enum logic [1:0] {
        PWT_APB_IDLE = 2'b01,
        PWT_APB_RESP = 2'b10
    } pwt_apb_e;
endpackage : pwt_pkg

//--- verilog/pwt_top.sv
// pwm generator with 8-bit period timer behind an apb slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "pwt_defs.svh"

module pwt_top (
    input wire logic sys_clk, // 100 mhz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write when high
    input wire pwt_pkg::pwt_addr_t paddr, // apb byte address
    input wire pwt_pkg::pwt_word_t pwdata, // apb write data
    output logic pready, // apb ready
    output pwt_pkg::pwt_word_t prdata, // apb read data
    output logic pslverr, // apb error on unmapped address
    output logic pulse_output_pin // modulated output
);
    import pwt_pkg::*;

    // bus state and registered outputs
    pwt_apb_e apb_q;
    logic pready_q;
    logic pslverr_q;
    pwt_word_t prdata_q;

    // software visible registers
    pwt_byte_t intr_ctl_q;
    pwt_byte_t pflags_q;
    pwt_byte_t pt_count_q;
    logic [6:0] pt_ctrl_q;
    pwt_byte_t duty_wr_q;
    pwt_byte_t duty_buf_q;
    logic [5:0] mod_ctrl_q;
    pwt_byte_t penables_q;
    pwt_byte_t plimit_q;

    // internal timing state
    logic [1:0] duty_lsb_q;
    logic [5:0] psc_q;
    logic [3:0] post_q;
    logic out_q;

    // combinational helpers
    logic wr_fire;
    logic run;
    logic [1:0] psc_sel;
    logic [5:0] psc_last;
    logic [1:0] sub_bits;
    logic tick;
    logic match;
    logic pwm_mode;
    logic [9:0] duty_next;
    logic duty_hit;
    logic post_done;
    // period boundary, flag event and software restarts of the timer
    logic period_end;
    logic flag_set;
    logic psc_clr;
    logic cnt_ld;
    // timer position one cycle ahead
    logic [5:0] psc_nx;
    logic [7:0] cnt_nx;
    pwt_byte_t rd_byte;
    logic rd_hit;

    // true when the byte address selects the register of that index
    function automatic logic addr_is(input pwt_addr_t addr, input pwt_byte_t idx);
        addr_is = (addr == {2'b00, idx, 2'b00});
    endfunction : addr_is

    // two sub-count bits of the extended compare for a prescale choice
    function automatic logic [1:0] sub_of(input logic [1:0] sel, input logic [5:0] psc);
        case (sel)
            2'b00: sub_of = psc[1:0]; // quarter cycle clock
            2'b01: sub_of = psc[3:2];
            default: sub_of = psc[5:4];
        endcase
    endfunction : sub_of

    // a write takes effect at the edge where pready is sampled high
    assign wr_fire = psel && penable && pwrite && (apb_q == PWT_APB_RESP);

    // prescale selection: 1, 4 or 16 instruction cycles per count
    assign run = pt_ctrl_q[`PWT_BIT_RUN];
    assign psc_sel = pt_ctrl_q[1:0];

    always_comb begin
        case (psc_sel)
            2'b00: begin
                psc_last = `PWT_PSC_LAST_1;
            end
            2'b01: begin
                psc_last = `PWT_PSC_LAST_4;
            end
            default: begin
                psc_last = `PWT_PSC_LAST_16;
            end
        endcase
    end

    // one increment cycle per prescaled instruction cycle, while running
    assign tick = run && (psc_q == psc_last);
    assign match = (pt_count_q == plimit_q);
    assign pwm_mode = (mod_ctrl_q[3:2] == `PWT_PWM_MODE);

    // a period ends on the increment after a limit match
    assign period_end = tick && match;

    // software writes that restart the prescaler
    assign psc_clr = wr_fire && (addr_is(paddr, `PWT_IDX_PT_COUNT) || addr_is(paddr, `PWT_IDX_PT_CTRL));

    // software write that loads the count
    assign cnt_ld = wr_fire && addr_is(paddr, `PWT_IDX_PT_COUNT);

    // next prescaler and count; the compare looks one cycle ahead so the pin falls on time
    always_comb begin
        psc_nx = psc_q;
        cnt_nx = pt_count_q;
        if (psc_clr || tick) begin
            psc_nx = 6'h00;
        end else if (run) begin
            psc_nx = psc_q + 6'h01;
        end
        if (cnt_ld) begin
            cnt_nx = pwdata[7:0];
        end else if (tick) begin
            cnt_nx = match ? 8'h00 : pt_count_q + 8'h01;
        end
    end

    // sub-count bits of the next position
    assign sub_bits = sub_of(psc_sel, psc_nx);

    // ten-bit duty from low register and control bits five to four
    assign duty_next = {duty_wr_q, mod_ctrl_q[5:4]};

    // pin falls when the extended count reaches the buffered duty
    assign duty_hit = ({cnt_nx, sub_bits} == {duty_buf_q, duty_lsb_q});

    // postscaler reaches its selected count of matches
    assign post_done = (post_q == pt_ctrl_q[6:3]);
    assign flag_set = period_end && post_done;

    // apb handshake: one wait cycle, then ready with data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            apb_q <= PWT_APB_IDLE;
            pready_q <= 1'b0;
        end else begin
            case (apb_q)
                PWT_APB_IDLE: begin
                    if (psel && penable) begin
                        apb_q <= PWT_APB_RESP;
                        pready_q <= 1'b1;
                    end
                end
                PWT_APB_RESP: begin
                    apb_q <= PWT_APB_IDLE;
                    pready_q <= 1'b0;
                end
                default: begin
                    apb_q <= PWT_APB_IDLE;
                    pready_q <= 1'b0;
                end
            endcase
        end
    end

    // read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = `PWT_RST_ZERO;
        if (addr_is(paddr, `PWT_IDX_INTR_CTL)) begin
            rd_byte = intr_ctl_q;
        end else if (addr_is(paddr, `PWT_IDX_PFLAGS)) begin
            rd_byte = pflags_q;
        end else if (addr_is(paddr, `PWT_IDX_PT_COUNT)) begin
            rd_byte = pt_count_q;
        end else if (addr_is(paddr, `PWT_IDX_PT_CTRL)) begin
            rd_byte = {1'b0, pt_ctrl_q};
        end else if (addr_is(paddr, `PWT_IDX_DUTY_WR)) begin
            rd_byte = duty_wr_q;
        end else if (addr_is(paddr, `PWT_IDX_DUTY_BUF)) begin
            rd_byte = duty_buf_q;
        end else if (addr_is(paddr, `PWT_IDX_MOD_CTRL)) begin
            rd_byte = {2'b00, mod_ctrl_q};
        end else if (addr_is(paddr, `PWT_IDX_PENABLES)) begin
            rd_byte = penables_q;
        end else if (addr_is(paddr, `PWT_IDX_PLIMIT)) begin
            rd_byte = plimit_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data and error are captured as ready rises
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_q == PWT_APB_IDLE && psel && penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= !rd_hit;
        end else if (apb_q == PWT_APB_RESP) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // interrupt control: global and peripheral enables plus storage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            intr_ctl_q <= `PWT_RST_ZERO;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_INTR_CTL)) begin
            intr_ctl_q <= pwdata[7:0];
        end
    end

    // peripheral flags; a match event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pflags_q <= `PWT_RST_ZERO;
        end else begin
            if (wr_fire && addr_is(paddr, `PWT_IDX_PFLAGS)) begin
                pflags_q <= pwdata[7:0];
            end
            if (flag_set) begin
                pflags_q[`PWT_BIT_MATCH] <= 1'b1;
            end
        end
    end

    // peripheral enables, match enable at bit one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            penables_q <= `PWT_RST_ZERO;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_PENABLES)) begin
            penables_q <= pwdata[7:0];
        end
    end

    // period limit, all ones after reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            plimit_q <= `PWT_RST_PLIMIT;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_PLIMIT)) begin
            plimit_q <= pwdata[7:0];
        end
    end

    // timer control: postscale, run and prescale fields
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pt_ctrl_q <= 7'h00;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_PT_CTRL)) begin
            pt_ctrl_q <= pwdata[6:0];
        end
    end

    // prescaler; cleared on writes to the count or control register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            psc_q <= 6'h00;
        end else begin
            psc_q <= psc_nx;
        end
    end

    // period timer: counts up, clears on the increment after a match
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pt_count_q <= `PWT_RST_ZERO;
        end else begin
            pt_count_q <= cnt_nx;
        end
    end

    // postscaler only paces the flag, never the pwm period
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            post_q <= 4'h0;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_PT_CTRL)) begin
            post_q <= 4'h0;
        end else if (period_end) begin
            post_q <= post_done ? 4'h0 : post_q + 4'h1;
        end
    end

    // duty write register, free to change at any time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            duty_wr_q <= `PWT_RST_ZERO;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_DUTY_WR)) begin
            duty_wr_q <= pwdata[7:0];
        end
    end

    // module control: duty low bits and mode select
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mod_ctrl_q <= 6'h00;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_MOD_CTRL)) begin
            mod_ctrl_q <= pwdata[5:0];
        end
    end

    // duty double buffer; loaded at a period match, read only in pwm mode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            duty_buf_q <= `PWT_RST_ZERO;
            duty_lsb_q <= 2'b00;
        end else if (pwm_mode && period_end) begin
            duty_buf_q <= duty_next[9:2];
            duty_lsb_q <= duty_next[1:0];
        end else if (!pwm_mode && wr_fire && addr_is(paddr, `PWT_IDX_DUTY_BUF)) begin
            duty_buf_q <= pwdata[7:0];
        end
    end

    // pulse output latch; period start sets it, duty compare clears it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_q <= 1'b0;
        end else if (wr_fire && addr_is(paddr, `PWT_IDX_MOD_CTRL) && pwdata[7:0] == 8'h00) begin
            out_q <= 1'b0;
        end else if (!pwm_mode) begin
            out_q <= 1'b0;
        end else if (period_end) begin
            out_q <= (duty_next != 10'h000);
        end else if (duty_hit) begin
            out_q <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pulse_output_pin = out_q;

endmodule : pwt_top
